// File: src/clock_state_consts.svh
// Offsets of the pin vector, polarities and timing counts for the clock state controller.
`ifndef CLOCK_STATE_CONSTS_SVH
`define CLOCK_STATE_CONSTS_SVH
`define PIN_STOP_CLOCK     0
`define PIN_SLEEP          1
`define PIN_BUS_INIT       2
`define PIN_SOFT_INIT      3
`define PIN_RESET_REQ      4
`define PIN_CACHE_FLUSH    5
`define PIN_SMI            6
`define PIN_NMI            7
`define PIN_MASKABLE_INTERRUPT           8
`define PIN_LINT0          9
`define PIN_LINT1          10
`define PIN_A20_MASK       11
`define PIN_PRIORITY_REQ   12
`define PIN_CLOCK_STOPPED  13
`define PIN_SNOOP          14
`define PIN_BUS_QUIET      15
`define PIN_STRAP          16
`define PIN_COUNT          17
`define PIN_LOW_ACTIVE     17'h1187f
`define EVENT_COUNT        6
`define EXIT_BUS_CLOCKS    10
`define SNOOP_QUIET_CLOCKS 2
`define DEEP_EXIT_TIME_MS  30
`define CLOCK_PERIOD_NS    8
`endif

// File: src/clock_state_pkg.sv
// Types shared by the clock state controller.
package clock_state_pkg;
  typedef enum logic [3:0] {
    ST_NORMAL,
    ST_AUTO_HALT,
    ST_STOP_GRANT,
    ST_QUICK_START,
    ST_SNOOP,
    ST_SLEEP,
    ST_DEEP_SLEEP,
    ST_DEEP_WAKE,
    ST_WAKE,
    ST_SLEEP_EXIT,
    ST_SERVICE
  } clock_state_t;
endpackage

// File: src/processor_clock_state_control.sv
// Processor low-power clock state controller.
// How it works
// - Halt instruction enters Auto Halt; any halt-break event returns to Normal.
// - Auto Halt still snoops; leaving it for Normal takes ten bus clocks.
// - Stop request in Auto Halt grants with acknowledge; release returns without Halt cycle.
// - Management interrupt recognized in Auto Halt; handler may resume Auto Halt silently.
// - Cache flush in Auto Halt is serviced, then Auto Halt resumes; A20 changes seen.
// - Strap sampled at reset picks Quick Start when low, else Stop Grant.
// - Stop Grant snoops and latches one of each event for service in Normal.
// - Stop Grant leaves on release, bus init or flush; exit takes ten clocks.
// - After bus init or flush in Stop Grant, return there unless request released.
// - Reset in Stop Grant or Quick Start initializes at once, stays in state.
// - Sleep entered only from Stop Grant; sleep request ignored in Normal and Auto Halt.
// - Quick Start acts only on priority snoops; ignores interrupts, flush, bus init.
// - Quick Start leaves for Normal, or Auto Halt if entered from there, only on stop release, taking ten clocks.
// - Snoop in low-power states enters snoop state until quiet, then returns.
// - Sleep keeps context, no snoops or latching; exit to Stop Grant takes ten clocks.
// - After the bus clock restarts, Sleep or Quick Start resumes after 30 ms.
`include "clock_state_consts.svh"

module processor_clock_state_control #(
  parameter int DEEP_EXIT_CYCLES = (`DEEP_EXIT_TIME_MS * 1000000) / `CLOCK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Pins from the system, asynchronous.
  input  wire logic        stop_clock_request_n_i,
  input  wire logic        sleep_request_n_i,
  input  wire logic        clock_state_select_strap_n_i,
  input  wire logic        bus_initialization_n_i,
  input  wire logic        soft_init_n_i,
  input  wire logic        reset_request_n_i,
  input  wire logic        cache_flush_request_n_i,
  input  wire logic        system_management_interrupt_n_i,
  input  wire logic        nonmaskable_interrupt_i,
  input  wire logic        maskable_interrupt_i,
  input  wire logic [1:0]  local_interrupt_lines_i,
  input  wire logic        address_bit20_mask_n_i,
  input  wire logic        priority_bus_request_n_i,
  input  wire logic        bus_clock_stopped_i,
  input  wire logic        snoop_request_i,
  input  wire logic        bus_quiet_i,
  // Core side, same clock.
  input  wire logic        halt_instruction_i,
  input  wire logic        smm_return_i,
  input  wire logic        smm_return_to_halt_i,
  input  wire logic        service_done_i,
  input  wire logic [5:0]  event_taken_i,
  // State and status.
  output clock_state_pkg::clock_state_t clock_state_o,
  output logic             core_clock_run_o,
  output logic             snoop_enable_o,
  output logic             service_events_o,
  output logic             quick_start_mode_o,
  output logic             address_bit20_mask_o,
  output logic [5:0]       pending_events_o,
  // Bus cycles and core commands, one-cycle pulses.
  output logic             halt_cycle_o,
  output logic             stop_grant_ack_o,
  output logic             flush_start_o,
  output logic             bus_init_start_o,
  output logic             core_init_o
);

  localparam int CW = $clog2(DEEP_EXIT_CYCLES + 1);
  localparam logic [CW-1:0] EXIT_LOAD  = CW'(`EXIT_BUS_CLOCKS - 1);
  localparam logic [CW-1:0] EXIT_LEN   = CW'(`EXIT_BUS_CLOCKS);
  localparam logic [CW-1:0] QUIET_LOAD = CW'(`SNOOP_QUIET_CLOCKS - 1);
  localparam logic [CW-1:0] DEEP_LOAD  = CW'(DEEP_EXIT_CYCLES - 1);

  clock_state_pkg::clock_state_t state;
  clock_state_pkg::clock_state_t next_state;
  clock_state_pkg::clock_state_t resume;
  clock_state_pkg::clock_state_t next_resume;
  clock_state_pkg::clock_state_t stop_state;

  logic [`PIN_COUNT-1:0]   pin_raw;
  logic [`PIN_COUNT-1:0]   pin_meta;
  logic [`PIN_COUNT-1:0]   pin_sync;
  logic [`PIN_COUNT-1:0]   act;
  logic [`PIN_COUNT-1:0]   act_prev;
  logic [`PIN_COUNT-1:0]   edge_on;
  logic [`EVENT_COUNT-1:0] ev_edge;
  logic [`EVENT_COUNT-1:0] pending;
  logic [CW-1:0]           count;
  logic [CW-1:0]           next_count;
  logic [CW-1:0]           timed_len;
  logic                    quick_start;
  logic                    from_halt;
  logic                    next_from_halt;
  logic                    a20_mask;
  logic                    next_ack;
  logic                    next_halt_cycle;
  logic                    next_flush;
  logic                    next_bus_initialization_n;
  logic                    next_init;
  logic                    latch_window;

  // Every pin passes two flip-flops; polarity is folded in only after the second.
  assign pin_raw = {clock_state_select_strap_n_i, bus_quiet_i, snoop_request_i,
                    bus_clock_stopped_i, priority_bus_request_n_i, address_bit20_mask_n_i,
                    local_interrupt_lines_i, maskable_interrupt_i, nonmaskable_interrupt_i,
                    system_management_interrupt_n_i, cache_flush_request_n_i,
                    reset_request_n_i, soft_init_n_i, bus_initialization_n_i,
                    sleep_request_n_i, stop_clock_request_n_i};

  // Synchroniser and edge history carry data only, so they need no reset.
  always_ff @(posedge clk_i)
  begin
    pin_meta <= pin_raw;
    pin_sync <= pin_meta;
    act_prev <= act;
  end

  // Active-high view of the pins and their assertion edges.
  assign act     = pin_sync ^ `PIN_LOW_ACTIVE;
  assign edge_on = act & ~act_prev;
  assign ev_edge = {edge_on[`PIN_MASKABLE_INTERRUPT], edge_on[`PIN_NMI], edge_on[`PIN_LINT1],
                    edge_on[`PIN_LINT0], edge_on[`PIN_SOFT_INIT], edge_on[`PIN_SMI]};

  // The strap is followed for as long as reset is held and frozen at release.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      quick_start <= act[`PIN_STRAP];
  end

  // The two stop states are mutually exclusive; the strap alone chooses.
  assign stop_state = quick_start ? clock_state_pkg::ST_QUICK_START
                                  : clock_state_pkg::ST_STOP_GRANT;

  // Events are latched wherever the core or the snoop logic still runs.
  // Quick Start and Sleep drop them: their inputs are meant to stand still.
  assign latch_window = !(state inside {clock_state_pkg::ST_QUICK_START,
                                        clock_state_pkg::ST_SLEEP,
                                        clock_state_pkg::ST_DEEP_SLEEP,
                                        clock_state_pkg::ST_DEEP_WAKE,
                                        clock_state_pkg::ST_SLEEP_EXIT})
                     && !(state == clock_state_pkg::ST_SNOOP
                          && resume == clock_state_pkg::ST_QUICK_START);

  // Next state; pins are read only through the synchronised view.
  always_comb
  begin
    next_state      = state;
    next_resume     = resume;
    next_count      = count;
    next_from_halt  = from_halt;
    next_ack        = 1'b0;
    next_halt_cycle = 1'b0;
    next_flush      = 1'b0;
    next_bus_initialization_n      = 1'b0;
    next_init       = 1'b0;
    unique case (state)
      clock_state_pkg::ST_NORMAL:
      begin
        if (act[`PIN_STOP_CLOCK])
        begin
          next_state     = stop_state;
          next_ack       = 1'b1;
          next_from_halt = 1'b0;
        end
        else if (halt_instruction_i)
        begin
          next_state      = clock_state_pkg::ST_AUTO_HALT;
          next_halt_cycle = 1'b1;
        end
        else if (smm_return_i && smm_return_to_halt_i)
          next_state = clock_state_pkg::ST_AUTO_HALT;
      end
      clock_state_pkg::ST_AUTO_HALT:
      begin
        if (act[`PIN_STOP_CLOCK])
        begin
          next_state     = stop_state;
          next_ack       = 1'b1;
          next_from_halt = 1'b1;
        end
        else if (edge_on[`PIN_CACHE_FLUSH])
        begin
          next_state  = clock_state_pkg::ST_SERVICE;
          next_resume = clock_state_pkg::ST_AUTO_HALT;
          next_flush  = 1'b1;
        end
        else if (act[`PIN_NMI] || act[`PIN_MASKABLE_INTERRUPT] || act[`PIN_SMI] || act[`PIN_SOFT_INIT]
                 || act[`PIN_BUS_INIT] || act[`PIN_RESET_REQ])
        begin
          next_state  = clock_state_pkg::ST_WAKE;
          next_resume = clock_state_pkg::ST_NORMAL;
          next_count  = EXIT_LOAD;
          next_bus_initialization_n  = edge_on[`PIN_BUS_INIT];
          next_init   = edge_on[`PIN_RESET_REQ];
        end
        else if (act[`PIN_SNOOP])
        begin
          next_state  = clock_state_pkg::ST_SNOOP;
          next_resume = clock_state_pkg::ST_AUTO_HALT;
          next_count  = QUIET_LOAD;
        end
      end
      clock_state_pkg::ST_STOP_GRANT:
      begin
        if (edge_on[`PIN_RESET_REQ])
          next_init = 1'b1;
        else if (!act[`PIN_STOP_CLOCK])
        begin
          next_state  = clock_state_pkg::ST_WAKE;
          next_resume = from_halt ? clock_state_pkg::ST_AUTO_HALT
                                  : clock_state_pkg::ST_NORMAL;
          next_count  = EXIT_LOAD;
        end
        else if (edge_on[`PIN_BUS_INIT] || edge_on[`PIN_CACHE_FLUSH])
        begin
          next_state  = clock_state_pkg::ST_SERVICE;
          next_resume = clock_state_pkg::ST_STOP_GRANT;
          next_bus_initialization_n  = edge_on[`PIN_BUS_INIT];
          next_flush  = edge_on[`PIN_CACHE_FLUSH];
        end
        else if (act[`PIN_SLEEP])
          next_state = clock_state_pkg::ST_SLEEP;
        else if (act[`PIN_SNOOP])
        begin
          next_state  = clock_state_pkg::ST_SNOOP;
          next_resume = clock_state_pkg::ST_STOP_GRANT;
          next_count  = QUIET_LOAD;
        end
      end
      clock_state_pkg::ST_QUICK_START:
      begin
        // Everything but these four inputs is assumed still here.
        if (edge_on[`PIN_RESET_REQ])
          next_init = 1'b1;
        else if (!act[`PIN_STOP_CLOCK])
        begin
          next_state  = clock_state_pkg::ST_WAKE;
          next_resume = from_halt ? clock_state_pkg::ST_AUTO_HALT
                                  : clock_state_pkg::ST_NORMAL;
          next_count  = EXIT_LOAD;
        end
        else if (act[`PIN_CLOCK_STOPPED])
        begin
          next_state  = clock_state_pkg::ST_DEEP_SLEEP;
          next_resume = clock_state_pkg::ST_QUICK_START;
        end
        else if (act[`PIN_PRIORITY_REQ])
        begin
          next_state  = clock_state_pkg::ST_SNOOP;
          next_resume = clock_state_pkg::ST_QUICK_START;
          next_count  = QUIET_LOAD;
        end
      end
      clock_state_pkg::ST_SNOOP:
      begin
        // From Quick Start only the priority agent may snoop.
        if ((resume == clock_state_pkg::ST_QUICK_START ? act[`PIN_PRIORITY_REQ]
                                                       : act[`PIN_SNOOP])
            || !act[`PIN_BUS_QUIET])
          next_count = QUIET_LOAD;
        else if (count == '0)
          next_state = resume;
        else
          next_count = count - CW'(1);
      end
      clock_state_pkg::ST_SLEEP:
      begin
        if (edge_on[`PIN_RESET_REQ])
        begin
          next_init  = 1'b1;
          next_state = clock_state_pkg::ST_STOP_GRANT;
        end
        else if (act[`PIN_CLOCK_STOPPED])
        begin
          next_state  = clock_state_pkg::ST_DEEP_SLEEP;
          next_resume = clock_state_pkg::ST_SLEEP;
        end
        else if (!act[`PIN_SLEEP])
        begin
          next_state = clock_state_pkg::ST_SLEEP_EXIT;
          next_count = EXIT_LOAD;
        end
      end
      clock_state_pkg::ST_DEEP_SLEEP:
      begin
        // Reset is not acted on here; the system must not raise it.
        if (!act[`PIN_CLOCK_STOPPED])
        begin
          next_state = clock_state_pkg::ST_DEEP_WAKE;
          next_count = DEEP_LOAD;
        end
      end
      clock_state_pkg::ST_DEEP_WAKE, clock_state_pkg::ST_WAKE:
      begin
        if (count == '0)
          next_state = resume;
        else
          next_count = count - CW'(1);
      end
      clock_state_pkg::ST_SLEEP_EXIT:
      begin
        if (count == '0)
          next_state = clock_state_pkg::ST_STOP_GRANT;
        else
          next_count = count - CW'(1);
      end
      clock_state_pkg::ST_SERVICE:
      begin
        if (service_done_i)
        begin
          if (resume == clock_state_pkg::ST_AUTO_HALT)
            next_state = clock_state_pkg::ST_AUTO_HALT;
          else if (act[`PIN_STOP_CLOCK])
            next_state = clock_state_pkg::ST_STOP_GRANT;
          else
          begin
            next_state  = clock_state_pkg::ST_WAKE;
            next_resume = clock_state_pkg::ST_NORMAL;
            next_count  = EXIT_LOAD;
          end
        end
      end
      default:
        next_state = clock_state_pkg::ST_NORMAL;
    endcase
  end

  // State, timers and one-cycle command pulses.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state            <= clock_state_pkg::ST_NORMAL;
      resume           <= clock_state_pkg::ST_NORMAL;
      count            <= '0;
      from_halt        <= 1'b0;
      stop_grant_ack_o <= 1'b0;
      halt_cycle_o     <= 1'b0;
      flush_start_o    <= 1'b0;
      bus_init_start_o <= 1'b0;
      core_init_o      <= 1'b0;
    end
    else
    begin
      state            <= next_state;
      resume           <= next_resume;
      count            <= next_count;
      from_halt        <= next_from_halt;
      stop_grant_ack_o <= next_ack;
      halt_cycle_o     <= next_halt_cycle;
      flush_start_o    <= next_flush;
      bus_init_start_o <= next_bus_initialization_n;
      core_init_o      <= next_init;
    end
  end

  // One occurrence per event is kept; a new edge beats a same-cycle clear.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pending <= '0;
    else
      pending <= (pending & ~event_taken_i) | (ev_edge & {`EVENT_COUNT{latch_window}});
  end

  // The address mask follows its pin only in Normal and Auto Halt, not in Service.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      a20_mask <= 1'b0;
    else if (state inside {clock_state_pkg::ST_NORMAL, clock_state_pkg::ST_AUTO_HALT})
      a20_mask <= act[`PIN_A20_MASK];
  end

  // Status outputs; latched events are released to the core only in Normal.
  assign clock_state_o        = state;
  assign quick_start_mode_o   = quick_start;
  assign address_bit20_mask_o = a20_mask;
  assign pending_events_o     = pending;
  assign service_events_o     = (state == clock_state_pkg::ST_NORMAL);
  assign core_clock_run_o     = (state inside {clock_state_pkg::ST_NORMAL,
                                               clock_state_pkg::ST_SERVICE});
  assign snoop_enable_o       = (state == clock_state_pkg::ST_SNOOP);

  // Cycles spent so far in a Wake or Sleep Exit (not Deep Wake), read only by the checks below.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      timed_len <= '0;
    else if (state inside {clock_state_pkg::ST_WAKE, clock_state_pkg::ST_SLEEP_EXIT})
      timed_len <= timed_len + CW'(1);
    else
      timed_len <= '0;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  AST_HALT_ENTRY: assert property (
    (state == clock_state_pkg::ST_NORMAL && !act[`PIN_STOP_CLOCK] && halt_instruction_i)
    |=> (state == clock_state_pkg::ST_AUTO_HALT && halt_cycle_o))
    else $error("halt instruction did not enter auto halt with a halt cycle");
  AST_WAKE_TEN: assert property (
    $fell(state == clock_state_pkg::ST_WAKE) |-> (timed_len == EXIT_LEN))
    else $error("exit to normal did not take ten clocks");
  AST_STOP_ACK: assert property (
    stop_grant_ack_o |-> (state == stop_state
      && ($past(state) inside {clock_state_pkg::ST_NORMAL, clock_state_pkg::ST_AUTO_HALT})))
    else $error("stop grant acknowledge without a stop entry");
  AST_HALT_CYCLE_ONCE: assert property (
    halt_cycle_o |-> $past(state) == clock_state_pkg::ST_NORMAL)
    else $error("halt cycle issued on a return to auto halt");
  AST_LATCH_EVENT: assert property (
    (state == clock_state_pkg::ST_STOP_GRANT && ev_edge[0]) |=> pending[0])
    else $error("management interrupt lost in stop grant");
  AST_SLEEP_FROM_GRANT: assert property (
    $rose(state == clock_state_pkg::ST_SLEEP)
    |-> ($past(state) inside {clock_state_pkg::ST_STOP_GRANT,
                              clock_state_pkg::ST_DEEP_WAKE}))
    else $error("sleep entered from a state other than stop grant");
  AST_RESET_STAYS: assert property (
    ((state inside {clock_state_pkg::ST_STOP_GRANT, clock_state_pkg::ST_QUICK_START})
      && edge_on[`PIN_RESET_REQ]) |=> (core_init_o && state == $past(state)))
    else $error("reset in a stop state left the state");
  AST_QS_IGNORES: assert property (
    (state == clock_state_pkg::ST_QUICK_START && act[`PIN_STOP_CLOCK] && !edge_on[`PIN_RESET_REQ]
      && !act[`PIN_CLOCK_STOPPED] && !act[`PIN_PRIORITY_REQ])
    |=> (state == clock_state_pkg::ST_QUICK_START && !flush_start_o && !bus_init_start_o))
    else $error("quick start reacted to an ignored input");
  AST_QS_SNOOP: assert property (
    (state == clock_state_pkg::ST_QUICK_START && act[`PIN_STOP_CLOCK] && !edge_on[`PIN_RESET_REQ]
      && !act[`PIN_CLOCK_STOPPED] && act[`PIN_PRIORITY_REQ])
    |=> state == clock_state_pkg::ST_SNOOP)
    else $error("priority snoop did not enter snoop state at once");
  AST_SLEEP_EXIT: assert property (
    $fell(state == clock_state_pkg::ST_SLEEP_EXIT)
    |-> (timed_len == EXIT_LEN && state == clock_state_pkg::ST_STOP_GRANT))
    else $error("sleep exit did not take ten clocks to stop grant");

endmodule

// File: dv/chipset_model.sv
// Chipset-side model that drives the stop, sleep, strap, reset and clock-gate pins.
module chipset_model
(
  // Clock, intent from the bench and device state.
  input  wire logic                    clk_i,
  input  wire logic                    quick_start_i,
  input  wire logic                    stop_i,
  input  wire logic                    sleep_i,
  input  wire logic                    gate_clock_i,
  input  wire logic                    reset_pin_i,
  input  clock_state_pkg::clock_state_t clock_state_i,
  // Pins toward the device.
  output logic                         stop_clock_request_n_o,
  output logic                         sleep_request_n_o,
  output logic                         reset_request_n_o,
  output logic                         clock_state_select_strap_n_o,
  output logic                         bus_clock_stopped_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins are registered, so the model adds one cycle; a reset in Sleep drops both requests.
  always_ff @(posedge clk_i)
  begin
    stop_clock_request_n_o <= !(stop_i
      && !(reset_pin_i && clock_state_i == clock_state_pkg::ST_SLEEP));
    sleep_request_n_o <= !(sleep_i && !quick_start_i && !reset_pin_i);
    reset_request_n_o <= !reset_pin_i;
    clock_state_select_strap_n_o <= !quick_start_i;
    // The clock is gated only where the device can take it, never on its own.
    bus_clock_stopped_o <= gate_clock_i && (clock_state_i inside {clock_state_pkg::ST_SLEEP,
      clock_state_pkg::ST_QUICK_START, clock_state_pkg::ST_DEEP_SLEEP});
  end
endmodule

// File: dv/processor_clock_state_control_test.sv
// Self-checking bench for the processor clock state controller.
module processor_clock_state_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_state_pkg::*;
  logic clk_i = 0, reset_i = 1, quick = 0, stop = 0, sleep = 0, gate = 0, rst_pin = 0;
  logic stop_n, sleep_n, strap_n, rst_n, clk_stopped;
  logic soft_n = 1, bus_initialization_n_n = 1, flush_n = 1, smi_n = 1, nmi = 0, maskable_interrupt = 0, a20_n = 1;
  logic prio_n = 1, snoop = 0, quiet = 1, halt = 0, smm_ret = 0, smm_halt = 0, done = 0;
  logic [1:0] lint = 2'h0;
  logic [5:0] taken = 6'h00;
  clock_state_t state;
  logic run, snp_en, svc, qs_mode, a20, halt_cyc, ack, fl_st, bi_st, c_init;
  logic [5:0] pending;
  int failures = 0, n_tests = 0, cycles = 0, took, halts = 0, seed, model_pending;

  chipset_model chipset_model_inst (.clk_i(clk_i), .quick_start_i(quick), .stop_i(stop),
    .sleep_i(sleep), .gate_clock_i(gate), .reset_pin_i(rst_pin), .clock_state_i(state),
    .stop_clock_request_n_o(stop_n), .sleep_request_n_o(sleep_n), .reset_request_n_o(rst_n),
    .clock_state_select_strap_n_o(strap_n), .bus_clock_stopped_o(clk_stopped));

  processor_clock_state_control #(.DEEP_EXIT_CYCLES(20)) processor_clock_state_control_inst (
    .clk_i(clk_i), .reset_i(reset_i), .stop_clock_request_n_i(stop_n),
    .sleep_request_n_i(sleep_n), .clock_state_select_strap_n_i(strap_n),
    .bus_initialization_n_i(bus_initialization_n_n), .soft_init_n_i(soft_n), .reset_request_n_i(rst_n),
    .cache_flush_request_n_i(flush_n), .system_management_interrupt_n_i(smi_n),
    .nonmaskable_interrupt_i(nmi), .maskable_interrupt_i(maskable_interrupt), .local_interrupt_lines_i(lint),
    .address_bit20_mask_n_i(a20_n), .priority_bus_request_n_i(prio_n),
    .bus_clock_stopped_i(clk_stopped), .snoop_request_i(snoop), .bus_quiet_i(quiet),
    .halt_instruction_i(halt), .smm_return_i(smm_ret), .smm_return_to_halt_i(smm_halt),
    .service_done_i(done), .event_taken_i(taken), .clock_state_o(state),
    .core_clock_run_o(run), .snoop_enable_o(snp_en), .service_events_o(svc),
    .quick_start_mode_o(qs_mode), .address_bit20_mask_o(a20), .pending_events_o(pending),
    .halt_cycle_o(halt_cyc), .stop_grant_ack_o(ack), .flush_start_o(fl_st),
    .bus_init_start_o(bi_st), .core_init_o(c_init));

  // An 8 ns bus clock.
  always #4 clk_i = ~clk_i;

  // Halt bus cycles are counted, and a hang is cut short after far more cycles than needed.
  always @(posedge clk_i)
  begin
    cycles++;
    if (halt_cyc === 1'b1)
      halts++;
    if (cycles == 3000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits a bounded number of cycles for a state, leaving the cycle count in took.
  task automatic reach(input clock_state_t s, input int lim);
    took = 0;
    #1;
    while (state !== s && took < lim)
    begin
      @(posedge clk_i);
      #1;
      took++;
    end
    check(32'(state), 32'(s));
  endtask

  task automatic do_reset(input logic qs);
    @(posedge clk_i);
    quick <= qs;
    reset_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
  endtask

  task automatic tally_and_finish();
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence: Stop Grant strap first, then Quick Start strap.
  initial
  begin
    seed = $urandom(32'h55ef);
    do_reset(1'b0);
    check(32'(state), 32'(ST_NORMAL));
    @(posedge clk_i) sleep <= 1'b1;
    a20_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1 check(32'(state), 32'(ST_NORMAL));
    check(32'(a20), 32'h1);
    @(posedge clk_i) sleep <= 1'b0;
    a20_n <= 1'b1;
    halt <= 1'b1;
    @(posedge clk_i) halt <= 1'b0;
    reach(ST_AUTO_HALT, 3);
    check(32'(halt_cyc), 32'h1);
    @(posedge clk_i) stop <= 1'b1;
    reach(ST_STOP_GRANT, 8);
    check(32'(ack), 32'h1);
    check(32'(run), 32'h0);
    model_pending = 1 | (32'($urandom_range(3, 1)) << 2);
    @(posedge clk_i) lint <= 2'(model_pending >> 2);
    smi_n <= 1'b0;
    @(posedge clk_i) lint <= 2'h0;
    smi_n <= 1'b1;
    repeat (4) @(posedge clk_i) smi_n <= ~smi_n;
    repeat (6) @(posedge clk_i);
    #1 check(32'(pending), 32'(model_pending));
    check(32'(state), 32'(ST_STOP_GRANT));
    @(posedge clk_i) flush_n <= 1'b0;
    bus_initialization_n_n <= 1'b0;
    reach(ST_SERVICE, 6);
    check(32'({fl_st, bi_st}), 32'h3);
    @(posedge clk_i) flush_n <= 1'b1;
    bus_initialization_n_n <= 1'b1;
    done <= 1'b1;
    @(posedge clk_i) done <= 1'b0;
    reach(ST_STOP_GRANT, 4);
    @(posedge clk_i) sleep <= 1'b1;
    reach(ST_SLEEP, 8);
    @(posedge clk_i) gate <= 1'b1;
    reach(ST_DEEP_SLEEP, 8);
    @(posedge clk_i) gate <= 1'b0;
    reach(ST_DEEP_WAKE, 8);
    reach(ST_SLEEP, 40);
    check(32'(took), 32'd20);
    @(posedge clk_i) sleep <= 1'b0;
    reach(ST_SLEEP_EXIT, 8);
    reach(ST_STOP_GRANT, 20);
    check(32'(took), 32'd10);
    seed = halts;
    @(posedge clk_i) stop <= 1'b0;
    reach(ST_WAKE, 8);
    reach(ST_AUTO_HALT, 20);
    check(32'(took), 32'd10);
    check(32'(halts), 32'(seed));
    @(posedge clk_i) maskable_interrupt <= 1'b1;
    reach(ST_NORMAL, 24);
    check(32'(svc), 32'h1);
    @(posedge clk_i) maskable_interrupt <= 1'b0;
    repeat (4) @(posedge clk_i);
    taken <= 6'h3f;
    @(posedge clk_i) taken <= 6'h00;
    #1 check(32'(pending), 32'h0);
    do_reset(1'b1);
    check(32'(qs_mode), 32'h1);
    @(posedge clk_i) stop <= 1'b1;
    reach(ST_QUICK_START, 8);
    @(posedge clk_i) prio_n <= 1'b0;
    reach(ST_SNOOP, 6);
    check(32'(snp_en), 32'h1);
    @(posedge clk_i) prio_n <= 1'b1;
    reach(ST_QUICK_START, 10);
    @(posedge clk_i) rst_pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 check(32'(c_init), 32'h1);
    check(32'(state), 32'(ST_QUICK_START));
    @(posedge clk_i) rst_pin <= 1'b0;
    @(posedge clk_i) gate <= 1'b1;
    reach(ST_DEEP_SLEEP, 8);
    @(posedge clk_i) gate <= 1'b0;
    reach(ST_DEEP_WAKE, 8);
    reach(ST_QUICK_START, 40);
    check(32'(took), 32'd20);
    @(posedge clk_i) stop <= 1'b0;
    reach(ST_WAKE, 8);
    reach(ST_NORMAL, 20);
    check(32'(took), 32'd10);
    tally_and_finish();
  end
endmodule
